// [common/piu_flag_if.sv]
// Link between the sequencer and the carry/zero flag bank.
`timescale 1ns/10ps
interface piu_flag_if;
    import piu_pkg::*;
    piu_mode_type flag_sel;
    logic alu_c;
    logic alu_z;
    logic flag_we;
    logic cur_c;
    logic cur_z;
    modport ctrl (output flag_sel, output alu_c, output alu_z, output flag_we,
                  input cur_c, input cur_z);
    modport bank (input flag_sel, input alu_c, input alu_z, input flag_we,
                  output cur_c, output cur_z);
endinterface : piu_flag_if

// [common/piu_pkg.sv]
// Shared constants, types and helpers of the prioritized interrupt unit.
package piu_pkg;

    // Register byte addresses on the APB.
    localparam logic [11:0] ADDR_OPTION = 12'h0c8;
    localparam logic [11:0] ADDR_STATUS = 12'h0cc;
    localparam logic [11:0] ADDR_EVENTS = 12'h0d0;

    // Option register layout and reset value.
    localparam int OPT_LES_BIT = 6;
    localparam int OPT_ESB_BIT = 5;
    localparam int OPT_GEN_BIT = 4;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam logic [7:0] OPT_USED_MASK = 8'h70;

    // Status register layout.
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_FSEL_LSB = 2;
    localparam int STAT_PEND_LSB = 4;
    localparam int STAT_CARRY_BIT = 9;
    localparam int STAT_ZERO_BIT = 10;
    localparam int STAT_WAKE_BIT = 11;

    // Vector addresses in program space.
    localparam logic [11:0] VEC_NMI = 12'hffc;
    localparam logic [11:0] VEC_SRC1 = 12'hff6;
    localparam logic [11:0] VEC_SRC2 = 12'hff4;
    localparam logic [11:0] VEC_SRC3 = 12'hff2;
    localparam logic [11:0] VEC_SRC4 = 12'hff0;

    // Source numbers; source zero is the non-maskable one.
    localparam logic [2:0] SRC_NMI = 3'h0;
    localparam logic [2:0] SRC_ONE = 3'h1;
    localparam logic [2:0] SRC_TWO = 3'h2;
    localparam logic [2:0] SRC_THREE = 3'h3;
    localparam logic [2:0] SRC_FOUR = 3'h4;

    typedef enum logic [1:0] {PIU_NORMAL, PIU_IRQ, PIU_NMI} piu_mode_type;

    // Highest priority maskable source; bit 0 is source one.
    function automatic logic [2:0] piu_first(input logic [3:0] req);
        logic [2:0] src;
        src = SRC_FOUR;
        if (req[2]) src = SRC_THREE;
        if (req[1]) src = SRC_TWO;
        if (req[0]) src = SRC_ONE;
        return src;
    endfunction : piu_first

    function automatic logic [11:0] piu_vector(input logic [2:0] src);
        logic [11:0] vec;
        vec = VEC_NMI;
        if (src == SRC_ONE) vec = VEC_SRC1;
        if (src == SRC_TWO) vec = VEC_SRC2;
        if (src == SRC_THREE) vec = VEC_SRC3;
        if (src == SRC_FOUR) vec = VEC_SRC4;
        return vec;
    endfunction : piu_vector

endpackage : piu_pkg

// [logic/piu_edge_latch.sv]
// Request capture for one line: falling/rising edge latch or plain low level.
`timescale 1ns/10ps
module piu_edge_latch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic line,
    input wire logic rise_sel,
    input wire logic level_mode,
    input wire logic clr,
    output logic req
);
    logic line_q;
    logic primed_q;
    logic latch_q;
    logic edge_hit;

    // The first sample after reset only primes the history, so a line idling low gives no edge.
    assign edge_hit = primed_q && (rise_sel ? (line & ~line_q) : (~line & line_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q <= 1'b1;
            primed_q <= 1'b0;
        end else if (ce) begin
            line_q <= line;
            primed_q <= 1'b1;
        end
    end

    // A new edge beats a clear in the same cycle; further edges merge into one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= 1'b0;
        end else if (ce) begin
            if (edge_hit && !level_mode) begin
                latch_q <= 1'b1;
            end else if (clr || level_mode) begin
                latch_q <= 1'b0;
            end
        end
    end

    assign req = level_mode ? ~line : latch_q;

    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        latch_q && !clr && !level_mode |=> latch_q)
        else $error("edge latch dropped a stored request");

endmodule : piu_edge_latch

// [logic/piu_flag_bank.sv]
// Three carry/zero flag pairs, one per operating mode, switched by selection.
`timescale 1ns/10ps
module piu_flag_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    piu_flag_if.bank fl
);
    import piu_pkg::*;

    logic normal_carry_flag_q;
    logic normal_zero_flag_q;
    logic irq_carry_flag_q;
    logic irq_zero_flag_q;
    logic nmi_carry_flag_q;
    logic nmi_zero_flag_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            normal_carry_flag_q <= 1'b0;
            normal_zero_flag_q <= 1'b0;
            irq_carry_flag_q <= 1'b0;
            irq_zero_flag_q <= 1'b0;
            nmi_carry_flag_q <= 1'b0;
            nmi_zero_flag_q <= 1'b0;
        end else if (ce && fl.flag_we) begin
            unique case (fl.flag_sel)
                PIU_NORMAL: begin
                    normal_carry_flag_q <= fl.alu_c;
                    normal_zero_flag_q <= fl.alu_z;
                end
                PIU_IRQ: begin
                    irq_carry_flag_q <= fl.alu_c;
                    irq_zero_flag_q <= fl.alu_z;
                end
                PIU_NMI: begin
                    nmi_carry_flag_q <= fl.alu_c;
                    nmi_zero_flag_q <= fl.alu_z;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        fl.cur_c = normal_carry_flag_q;
        fl.cur_z = normal_zero_flag_q;
        if (fl.flag_sel == PIU_IRQ) begin
            fl.cur_c = irq_carry_flag_q;
            fl.cur_z = irq_zero_flag_q;
        end else if (fl.flag_sel == PIU_NMI) begin
            fl.cur_c = nmi_carry_flag_q;
            fl.cur_z = nmi_zero_flag_q;
        end
    end

    a_normal_kept: assert property (@(posedge pclk) disable iff (!presetn)
        fl.flag_sel != PIU_NORMAL |=> $stable(normal_carry_flag_q) && $stable(normal_zero_flag_q))
        else $error("normal flag pair changed outside normal selection");

endmodule : piu_flag_bank

// [logic/piu_unit.sv]
// Prioritized interrupt unit: option register, arbitration, entry and return sequencing.
`timescale 1ns/10ps
module piu_unit #(
    parameter int unsigned SRC3_EVENTS = 3,
    parameter int unsigned SRC4_EVENTS = 1,
    parameter bit FLAG_ANOMALY = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nmi_n,
    input wire logic src1_n,
    input wire logic src2_pin,
    input wire logic [SRC3_EVENTS-1:0] src3_evt,
    input wire logic [SRC4_EVENTS-1:0] src4_evt,
    input wire logic instr_end,
    input wire logic return_from_interrupt,
    input wire logic core_sleep,
    input wire logic ior_write_busy,
    input wire logic [11:0] pc_current,
    input wire logic alu_c,
    input wire logic alu_z,
    input wire logic flag_we,
    output logic irq_take,
    output logic [2:0] irq_source,
    output logic [11:0] vector_addr,
    output logic stack_push,
    output logic [11:0] stack_push_data,
    output logic stack_pop,
    output logic wake,
    output logic cur_c,
    output logic cur_z,
    output piu_pkg::piu_mode_type cpu_mode
);
    import piu_pkg::*;

    localparam int unsigned NEVT = SRC3_EVENTS + SRC4_EVENTS;

    logic [7:0] interrupt_option_reg_q;
    logic global_irq_enable;
    logic src2_edge_polarity;
    logic src1_level_edge_select;
    logic [NEVT-1:0] evt_flags_q;
    logic [31:0] prdata_q;
    piu_mode_type mode_q;
    piu_mode_type prev_mode_q;
    piu_mode_type flag_sel_q;
    piu_mode_type prev_flag_q;
    piu_mode_type mode_eff;
    piu_mode_type flag_eff;
    logic take_q;
    logic [2:0] take_src_q;
    logic [11:0] vector_q;
    logic push_q;
    logic [11:0] push_data_q;
    logic pop_q;
    logic nmi_req;
    logic src1_req;
    logic src2_req;
    logic [3:0] mreq;
    logic sample;
    logic take_nmi;
    logic take_mask;
    logic accept;
    logic [2:0] acc_src;
    logic keep_flags;
    logic clr_nmi;
    logic clr_src1;
    logic clr_src2;
    logic setup_rd;
    logic acc_wr;
    logic addr_hit;

    piu_flag_if flags ();

    assign global_irq_enable = interrupt_option_reg_q[OPT_GEN_BIT];
    assign src2_edge_polarity = interrupt_option_reg_q[OPT_ESB_BIT];
    assign src1_level_edge_select = interrupt_option_reg_q[OPT_LES_BIT];

    // APB slave: zero wait states while the clock enable is high.
    assign addr_hit = (paddr == ADDR_OPTION) || (paddr == ADDR_STATUS) ||
                      (paddr == ADDR_EVENTS);
    assign pready = ce;
    assign pslverr = psel && penable && !addr_hit;
    assign setup_rd = psel && !penable && !pwrite;
    assign acc_wr = ce && psel && penable && pwrite && addr_hit;
    assign prdata = prdata_q;

    // Only bits six to four are stored; a write needs the low byte lane.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_option_reg_q <= OPT_RESET;
        end else if (acc_wr && paddr == ADDR_OPTION && pstrb[0]) begin
            interrupt_option_reg_q <= pwdata[7:0] & OPT_USED_MASK;
        end
    end

    // Per-event poll flags; a new event wins over a software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_flags_q <= '0;
        end else if (ce) begin
            if (acc_wr && paddr == ADDR_EVENTS) begin
                evt_flags_q <= (evt_flags_q & ~pwdata[NEVT-1:0]) | {src4_evt, src3_evt};
            end else begin
                evt_flags_q <= evt_flags_q | {src4_evt, src3_evt};
            end
        end
    end

    // Read data is captured in the setup cycle; the option register reads zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (ce && setup_rd) begin
            prdata_q <= 32'h0000_0000;
            if (paddr == ADDR_STATUS) begin
                prdata_q[STAT_MODE_LSB +: 2] <= mode_q;
                prdata_q[STAT_FSEL_LSB +: 2] <= flag_sel_q;
                prdata_q[STAT_PEND_LSB +: 5] <= {mreq, nmi_req};
                prdata_q[STAT_CARRY_BIT] <= flags.cur_c;
                prdata_q[STAT_ZERO_BIT] <= flags.cur_z;
                prdata_q[STAT_WAKE_BIT] <= wake;
            end else if (paddr == ADDR_EVENTS) begin
                prdata_q[NEVT-1:0] <= evt_flags_q;
            end
        end
    end

    piu_edge_latch u_nmi (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .line(nmi_n),
        .rise_sel(1'b0),
        .level_mode(1'b0),
        .clr(clr_nmi),
        .req(nmi_req)
    );

    piu_edge_latch u_src1 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .line(src1_n),
        .rise_sel(1'b0),
        .level_mode(src1_level_edge_select),
        .clr(clr_src1),
        .req(src1_req)
    );

    piu_edge_latch u_src2 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .line(src2_pin),
        .rise_sel(src2_edge_polarity),
        .level_mode(1'b0),
        .clr(clr_src2),
        .req(src2_req)
    );

    // Sources three and four pass straight through as levels.
    assign mreq = {|src4_evt, |src3_evt, src2_req, src1_req};

    // A return restores the earlier mode first, so pending work is seen at once.
    assign mode_eff = return_from_interrupt ? prev_mode_q : mode_q;
    assign flag_eff = return_from_interrupt ? prev_flag_q : flag_sel_q;
    assign sample = ce && instr_end;
    assign take_nmi = nmi_req && (mode_eff != PIU_NMI);
    assign take_mask = global_irq_enable && (mode_eff == PIU_NORMAL) && (|mreq);
    assign accept = sample && (take_nmi || take_mask);
    assign acc_src = take_nmi ? SRC_NMI : piu_first(mreq);
    assign keep_flags = FLAG_ANOMALY && ior_write_busy && !take_nmi;
    assign clr_nmi = accept && (acc_src == SRC_NMI);
    assign clr_src1 = accept && (acc_src == SRC_ONE);
    assign clr_src2 = accept && (acc_src == SRC_TWO);

    // Wake needs the global enable, even for the non-maskable source.
    assign wake = core_sleep && global_irq_enable && (nmi_req || (|mreq));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= PIU_NMI;
            prev_mode_q <= PIU_NORMAL;
        end else if (ce) begin
            if (accept) begin
                prev_mode_q <= mode_eff;
                mode_q <= take_nmi ? PIU_NMI : PIU_IRQ;
            end else if (sample && return_from_interrupt) begin
                mode_q <= prev_mode_q;
                prev_mode_q <= PIU_NORMAL;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_sel_q <= PIU_NMI;
            prev_flag_q <= PIU_NORMAL;
        end else if (ce) begin
            if (accept) begin
                prev_flag_q <= flag_eff;
                if (take_nmi) begin
                    flag_sel_q <= PIU_NMI;
                end else if (keep_flags) begin
                    flag_sel_q <= flag_eff;
                end else begin
                    flag_sel_q <= PIU_IRQ;
                end
            end else if (sample && return_from_interrupt) begin
                flag_sel_q <= prev_flag_q;
                prev_flag_q <= PIU_NORMAL;
            end
        end
    end

    // Entry, one cycle after acceptance: flag the take, push the counter, jump to the vector.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_q <= 1'b0;
            take_src_q <= SRC_NMI;
            vector_q <= VEC_NMI;
            push_q <= 1'b0;
            push_data_q <= 12'h000;
            pop_q <= 1'b0;
        end else if (ce) begin
            take_q <= accept;
            push_q <= accept;
            pop_q <= sample && return_from_interrupt;
            if (accept) begin
                take_src_q <= acc_src;
                vector_q <= piu_vector(acc_src);
                push_data_q <= pc_current;
            end
        end
    end

    assign irq_take = take_q;
    assign irq_source = take_src_q;
    assign vector_addr = vector_q;
    assign stack_push = push_q;
    assign stack_push_data = push_data_q;
    assign stack_pop = pop_q;
    assign cpu_mode = mode_q;

    assign flags.flag_sel = flag_sel_q;
    assign flags.alu_c = alu_c;
    assign flags.alu_z = alu_z;
    assign flags.flag_we = flag_we;
    assign cur_c = flags.cur_c;
    assign cur_z = flags.cur_z;

    piu_flag_bank u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .fl(flags.bank)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_entry_req;
        sample && (take_nmi || take_mask);
    endsequence

    sequence s_entry_done;
        take_q && push_q && (push_data_q == $past(pc_current));
    endsequence

    a_entry_push: assert property (s_entry_req |=> s_entry_done)
        else $error("entry did not push the program counter");

    a_prio_order: assert property (
        take_q && take_src_q != SRC_NMI |-> !(|($past(mreq) & ((4'h1 << (take_src_q - 3'h1)) - 4'h1))))
        else $error("lower priority source taken before a higher one");

    a_vector_map: assert property (
        take_q && take_src_q == SRC_THREE |-> vector_addr == VEC_SRC3)
        else $error("wrong vector for source three");

    a_nmi_vector: assert property (take_q && take_src_q == SRC_NMI |->
        vector_addr == VEC_NMI && mode_q == PIU_NMI)
        else $error("non-maskable entry with wrong vector or mode");

    a_no_nesting: assert property (
        sample && mode_eff != PIU_NORMAL && !take_nmi |=> !take_q)
        else $error("maskable request nested into a service routine");

    a_gen_block: assert property (
        sample && !global_irq_enable && !nmi_req |=> !take_q)
        else $error("maskable request taken with global enable clear");

    a_nmi_nowake: assert property (!global_irq_enable |-> !wake)
        else $error("wake raised with global enable clear");

    a_nmi_taken: assert property (
        sample && nmi_req && mode_q != PIU_NMI |=> take_q && take_src_q == SRC_NMI)
        else $error("pending non-maskable request not taken");

    a_flag_switch: assert property (
        take_q && take_src_q != SRC_NMI && !$past(keep_flags) |-> flag_sel_q == PIU_IRQ)
        else $error("maskable entry did not select the interrupt flag pair");

    a_return_pop: assert property (
        sample && return_from_interrupt && !accept |=> stack_pop && mode_q == $past(prev_mode_q))
        else $error("return did not pop and restore the mode");

    a_src1_clear: assert property (
        sample && !src1_level_edge_select && take_mask && !take_nmi && src1_req |=>
        take_src_q == SRC_ONE ##0 (!src1_req || $past(src1_n, 2) != $past(src1_n, 1)))
        else $error("source one latch not cleared on entry");

endmodule : piu_unit

// [verification/piu_core_model.sv]
// Behavioural processor core that paces instructions and issues returns.
`timescale 1ns/10ps
module piu_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ret_go,
    output logic instr_end,
    output logic return_from_interrupt,
    output logic [11:0] pc_current
);
    logic [1:0] slot_q;
    logic ret_q;

    // Every instruction lasts four cycles; the last one is the sampling point.
    assign instr_end = (slot_q == 2'h3);
    assign return_from_interrupt = instr_end & ret_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_q <= 2'h0;
        end else begin
            slot_q <= slot_q + 2'h1;
        end
    end

    // A requested return is issued on the next instruction boundary.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_q <= 1'b0;
        end else if (ret_go) begin
            ret_q <= 1'b1;
        end else if (instr_end) begin
            ret_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_current <= 12'h100;
        end else if (instr_end) begin
            pc_current <= pc_current + 12'h1;
        end
    end
endmodule : piu_core_model

// [verification/tb_top.sv]
// Self-checking testbench of the prioritized interrupt unit.
`timescale 1ns/10ps
module tb_top;
    import piu_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0, pc_current;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, nmi_n = 1, src1_n = 1, src2_pin = 0, core_sleep = 0;
    logic [2:0] src3_evt = 3'h0;
    logic [0:0] src4_evt = 1'h0;
    logic instr_end, rfi, ret_go = 0, alu_c = 0, alu_z = 0, flag_we = 0, ior_busy = 0;
    logic irq_take, stack_push, stack_pop, wake, cur_c, cur_z, got, pushed, popped, err;
    logic [2:0] irq_source;
    logic [11:0] vector_addr, stack_push_data;
    piu_mode_type cpu_mode;
    int fail_count = 0, n_tests = 0;

    piu_core_model core_u (.pclk(pclk), .presetn(presetn), .ret_go(ret_go),
        .instr_end(instr_end), .return_from_interrupt(rfi), .pc_current(pc_current));
    piu_unit #(.FLAG_ANOMALY(1'b1)) dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nmi_n(nmi_n), .src1_n(src1_n), .src2_pin(src2_pin), .src3_evt(src3_evt),
        .src4_evt(src4_evt), .instr_end(instr_end), .return_from_interrupt(rfi),
        .core_sleep(core_sleep), .ior_write_busy(ior_busy), .pc_current(pc_current),
        .alu_c(alu_c), .alu_z(alu_z), .flag_we(flag_we), .irq_take(irq_take),
        .irq_source(irq_source), .vector_addr(vector_addr), .stack_push(stack_push),
        .stack_push_data(stack_push_data), .stack_pop(stack_pop), .wake(wake),
        .cur_c(cur_c), .cur_z(cur_z), .cpu_mode(cpu_mode));

    initial begin
        forever #4 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic wait_take(input int n);
        got = 0;
        for (int i = 0; i < n && !got; i++) begin
            @(posedge pclk);
            #1;
            pushed = stack_push;
            got = (irq_take === 1'b1);
        end
    endtask : wait_take

    task automatic do_ret();
        @(posedge pclk);
        ret_go <= 1;
        @(posedge pclk);
        ret_go <= 0;
        popped = 0;
        got = 0;
        for (int i = 0; i < 12 && !popped && !got; i++) begin
            @(posedge pclk);
            #1;
            popped = (stack_pop === 1'b1);
            got = (irq_take === 1'b1);
        end
    endtask : do_ret

    // Pin 0 is the non-maskable line, pin 1 source one, pin 2 source two.
    task automatic pulse(input int pin, input logic v);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            if (pin == 0) begin
                nmi_n <= v ^ k[0];
            end else if (pin == 1) begin
                src1_n <= v ^ k[0];
            end else begin
                src2_pin <= v ^ k[0];
            end
        end
    endtask : pulse

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        #1;
        check(cpu_mode, PIU_NMI);
        apb(0, ADDR_OPTION, 32'h0);
        check(rd, 32'h0);
        apb(0, 12'h0fc, 32'h0);
        check(err, 1'b1);
        do_ret();
        check({popped, cpu_mode}, {1'b1, PIU_NORMAL});
        @(posedge pclk);
        {alu_c, alu_z, flag_we} <= 3'b101;
        @(posedge pclk);
        flag_we <= 0;
        #1;
        check({cur_c, cur_z}, 2'b10);
        $display("test reset and return done");

        src3_evt <= 3'b010;
        wait_take(16);
        check(got, 1'b0);
        apb(1, ADDR_OPTION, 32'h30);
        wait_take(16);
        // The level request is held until it has been sampled.
        src3_evt <= 3'b000;
        check({got, pushed, irq_source}, {2'b11, SRC_THREE});
        check(vector_addr, VEC_SRC3);
        check({cpu_mode, cur_c, cur_z}, {PIU_IRQ, 2'b00});
        apb(0, ADDR_EVENTS, 32'h0);
        check(rd, 32'h2);
        apb(1, ADDR_EVENTS, 32'h2);
        apb(0, ADDR_EVENTS, 32'h0);
        check(rd, 32'h0);
        $display("test masking and entry done");

        pulse(1, 1'b0);
        pulse(2, 1'b1);
        pulse(2, 1'b1);
        wait_take(16);
        check(got, 1'b0);
        do_ret();
        check({got, irq_source, vector_addr}, {1'b1, SRC_ONE, VEC_SRC1});
        do_ret();
        check({got, irq_source, vector_addr}, {1'b1, SRC_TWO, VEC_SRC2});
        do_ret();
        check({got, popped, cpu_mode}, {2'b01, PIU_NORMAL});
        check({cur_c, cur_z}, 2'b10);
        $display("test priority and latching done");

        apb(1, ADDR_OPTION, 32'h50);
        src1_n <= 0;
        wait_take(16);
        check({got, irq_source}, {1'b1, SRC_ONE});
        pulse(0, 1'b0);
        wait_take(16);
        src1_n <= 1;
        check({got, irq_source, vector_addr}, {1'b1, SRC_NMI, VEC_NMI});
        check(cpu_mode, PIU_NMI);
        do_ret();
        do_ret();
        check({got, popped}, 2'b01);
        $display("test level mode and preemption done");

        apb(1, ADDR_OPTION, 32'h00);
        core_sleep <= 1;
        pulse(0, 1'b0);
        #1;
        check(wake, 1'b0);
        wait_take(16);
        core_sleep <= 0;
        check({got, irq_source}, {1'b1, SRC_NMI});
        do_ret();
        apb(1, ADDR_OPTION, 32'h10);
        src2_pin <= 1'b1;
        wait_take(6);
        check(got, 1'b0);
        src2_pin <= 0;
        wait_take(16);
        check({got, irq_source}, {1'b1, SRC_TWO});
        do_ret();
        src4_evt <= 1'b1;
        core_sleep <= 1;
        #1;
        check(wake, 1'b1);
        wait_take(16);
        src4_evt <= 1'b0;
        core_sleep <= 0;
        check({got, irq_source, vector_addr}, {1'b1, SRC_FOUR, VEC_SRC4});
        do_ret();
        ior_busy <= 1;
        src3_evt <= 3'b001;
        wait_take(16);
        src3_evt <= 3'b000;
        ior_busy <= 0;
        check({got, cpu_mode, cur_c, cur_z}, {1'b1, PIU_IRQ, 2'b10});
        $display("test enable and wake done");
        stop_test();
    end
endmodule : tb_top
